// *** pecint_pins.sv ***
// Model of the outside signals that drive the pins of both ports
`timescale 1ns/1ps

module pecint_pins (
  // Clock
  input wire logic sys_clk,
  // Levels asked for by the bench
  input wire logic [7:0] want_a,
  input wire logic [7:0] want_b,
  // Pins
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins
);
  // Pins follow the asked levels one cycle later, so each level lasts
  // exactly as long as the bench holds it; no minimum length is imposed
  always_ff @(posedge sys_clk) begin
    port_a_pins <= want_a;
    port_b_pins <= want_b;
  end
endmodule : pecint_pins

// *** pecint_pkg.sv ***
// Constants, register map and carrier types of the pin edge change block
package pecint_pkg;

  // ********************************************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ********************************************************************
  localparam logic [4:0] OFS_A_RISE = 5'h00;
  localparam logic [4:0] OFS_A_FALL = 5'h04;
  localparam logic [4:0] OFS_A_FLAGS = 5'h08;
  localparam logic [4:0] OFS_B_RISE = 5'h0C;
  localparam logic [4:0] OFS_B_FALL = 5'h10;
  localparam logic [4:0] OFS_B_FLAGS = 5'h14;
  localparam logic [4:0] OFS_CTRL = 5'h18;

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam logic [7:0] A_PIN_MASK = 8'h3B;
  localparam logic [7:0] B_PIN_MASK = 8'hF0;
  localparam logic [1:0][7:0] PIN_MASK = {B_PIN_MASK, A_PIN_MASK};
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CTRL_MASTER_BIT = 4;
  localparam int CTRL_SUMMARY_BIT = 0;
  localparam int PRIME_DEPTH = 3;

  // Register field selector
  typedef enum logic [1:0] {
    FLD_RISE = 2'b00,
    FLD_FALL = 2'b01,
    FLD_FLAGS = 2'b10,
    FLD_CTRL = 2'b11
  } pecint_field_t;

  // Decoded bus address
  typedef struct packed {
    logic valid;
    logic port;
    pecint_field_t field;
  } pecint_sel_t;

  // Per-port register set
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
  } pecint_port_t;

  localparam pecint_port_t PORT_RST = '{RST_BYTE, RST_BYTE, RST_BYTE};

endpackage : pecint_pkg

// *** pecint_top.sv ***
// Pin edge change detector with Avalon-MM register slave
//
// How it works
// - Edge detection on implemented pins of both ports, any pin combination.
// - Interrupt raised only with master enable; flags still set without it.
// - Per-pin rising detector, active only while its rise enable bit set.
// - Per-pin falling detector, active only while its fall enable bit set.
// - Both enables set means both edge directions are detected together.
// - Enabled edge sets the pin flag, requests interrupt under master enable.
// - Summary flag is the OR of every flag of both ports.
// - Software clears a flag by writing zero; otherwise it stays set.
// - Edge during the clearing write leaves the flag set afterward.
// - Enabled pin change wakes the device from sleep under master enable.
// - Flag updated no later than the wake request during sleep.
// - Port A rise enable: bits 5-3 and 1-0 writable, others read zero.
// - Port A fall enable uses the same implemented bits, reset zero.
// - Port A flags: bits 5-3, 1-0, hardware set, software clear.
// - Port A pins zero and one detect only with input buffers enabled.
// - Port B supports bits 7-4 only; bits 3-0 read zero.
`timescale 1ns/1ps

module pecint_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port pins, asynchronous
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  // Same-clock status from the core
  input wire logic [1:0] port_a_buf_en,
  input wire logic sleep_mode,
  // Event outputs
  output logic change_irq,
  output logic change_summary_flag,
  output logic wake_req
);

  // ********************************************************************
  // Functions
  // ********************************************************************

  // Address decoder, shared by the write path and the read mux
  function automatic pecint_pkg::pecint_sel_t decode(input logic [4:0] a);
    pecint_pkg::pecint_sel_t s;
    s = '{1'b1, 1'b0, pecint_pkg::FLD_CTRL};
    unique case (a)
      pecint_pkg::OFS_A_RISE: s = '{1'b1, 1'b0, pecint_pkg::FLD_RISE};
      pecint_pkg::OFS_A_FALL: s = '{1'b1, 1'b0, pecint_pkg::FLD_FALL};
      pecint_pkg::OFS_A_FLAGS: s = '{1'b1, 1'b0, pecint_pkg::FLD_FLAGS};
      pecint_pkg::OFS_B_RISE: s = '{1'b1, 1'b1, pecint_pkg::FLD_RISE};
      pecint_pkg::OFS_B_FALL: s = '{1'b1, 1'b1, pecint_pkg::FLD_FALL};
      pecint_pkg::OFS_B_FLAGS: s = '{1'b1, 1'b1, pecint_pkg::FLD_FLAGS};
      pecint_pkg::OFS_CTRL: s = '{1'b1, 1'b0, pecint_pkg::FLD_CTRL};
      default: s = '{1'b0, 1'b0, pecint_pkg::FLD_CTRL};
    endcase
    return s;
  endfunction : decode

  // Qualified transition: new level high, old level low, enabled, usable
  function automatic logic [7:0] edge_of(input logic [7:0] now_v,
                                         input logic [7:0] old_v,
                                         input logic [7:0] en,
                                         input logic [7:0] mask);
    return now_v & ~old_v & en & mask;
  endfunction : edge_of

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [1:0][7:0] pin_meta_ff;
  logic [1:0][7:0] pin_sync_ff;
  logic [1:0][7:0] pin_prev_ff;
  logic [pecint_pkg::PRIME_DEPTH-1:0] prime_ff;
  logic armed;
  logic [1:0][7:0] det_mask;
  logic [1:0][7:0] rise_ev;
  logic [1:0][7:0] fall_ev;
  logic [1:0][7:0] any_ev;
  pecint_pkg::pecint_port_t [1:0] port_ff;
  logic master_ff;
  logic wake_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic bus_req;
  logic wr_go;
  pecint_pkg::pecint_sel_t sel;

  // ********************************************************************
  // Pin synchronisers and edge detection
  // ********************************************************************

  // Two flops per pin; the third keeps the previous settled sample
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_meta_ff <= {port_b_pins, port_a_pins};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // Blocks detection until the pipeline holds real pin samples, so a pin
  // that is high at reset does not fake a rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prime_ff <= '0;
    end else begin
      prime_ff <= {prime_ff[pecint_pkg::PRIME_DEPTH-2:0], 1'b1};
    end
  end

  assign armed = prime_ff[pecint_pkg::PRIME_DEPTH-1];

  // Pins zero and one of port A have no input buffer while USB owns them
  assign det_mask[0] = pecint_pkg::PIN_MASK[0]
                       & {6'h3F, port_a_buf_en};
  assign det_mask[1] = pecint_pkg::PIN_MASK[1];

  // Independent rise and fall detectors per pin; both may be enabled
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rise_ev[p] = armed ? edge_of(pin_sync_ff[p], pin_prev_ff[p],
                                   port_ff[p].rise, det_mask[p])
                         : 8'h00;
      fall_ev[p] = armed ? edge_of(pin_prev_ff[p], pin_sync_ff[p],
                                   port_ff[p].fall, det_mask[p])
                         : 8'h00;
      any_ev[p] = rise_ev[p] | fall_ev[p];
    end
  end

  // ********************************************************************
  // Avalon-MM slave
  // ********************************************************************

  // One wait cycle on every access; read data is latched in that cycle
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign sel = decode(avs_address);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Read mux; unmapped offsets and unimplemented bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel.valid) begin
      unique case (sel.field)
        pecint_pkg::FLD_RISE: nxt_rdata[7:0] = port_ff[sel.port].rise;
        pecint_pkg::FLD_FALL: nxt_rdata[7:0] = port_ff[sel.port].fall;
        pecint_pkg::FLD_FLAGS: nxt_rdata[7:0] = port_ff[sel.port].flags;
        pecint_pkg::FLD_CTRL: begin
          nxt_rdata[pecint_pkg::CTRL_MASTER_BIT] = master_ff;
          nxt_rdata[pecint_pkg::CTRL_SUMMARY_BIT] = change_summary_flag;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;

  // ********************************************************************
  // Registers
  // ********************************************************************

  // Enables and sticky flags share one process because they sit in one
  // packed register set; unimplemented bits never store. A written zero
  // clears a flag, but a new edge in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      port_ff <= {pecint_pkg::PORT_RST, pecint_pkg::PORT_RST};
    end else begin
      if (wr_go && sel.valid && sel.field == pecint_pkg::FLD_RISE) begin
        port_ff[sel.port].rise <= avs_writedata[7:0]
                                  & pecint_pkg::PIN_MASK[sel.port];
      end
      if (wr_go && sel.valid && sel.field == pecint_pkg::FLD_FALL) begin
        port_ff[sel.port].fall <= avs_writedata[7:0]
                                  & pecint_pkg::PIN_MASK[sel.port];
      end
      for (int p = 0; p < 2; p++) begin
        if (wr_go && sel.valid && sel.field == pecint_pkg::FLD_FLAGS
            && sel.port == p[0]) begin
          port_ff[p].flags <= ((port_ff[p].flags & avs_writedata[7:0])
                               | any_ev[p])
                              & pecint_pkg::PIN_MASK[p];
        end else begin
          port_ff[p].flags <= (port_ff[p].flags | any_ev[p])
                              & pecint_pkg::PIN_MASK[p];
        end
      end
    end
  end

  // Master enable in the control register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      master_ff <= 1'b0;
    end else if (wr_go && sel.valid && sel.field == pecint_pkg::FLD_CTRL) begin
      master_ff <= avs_writedata[pecint_pkg::CTRL_MASTER_BIT];
    end
  end

  // ********************************************************************
  // Summary, interrupt and wake
  // ********************************************************************

  // Both are gates over flops, so they glitch-free follow the registers
  assign change_summary_flag = |{port_ff[1].flags, port_ff[0].flags};
  assign change_irq = master_ff & change_summary_flag;

  // Wake pulse rises on the same edge that sets the flag, so the flag
  // is already visible when the core resumes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= sleep_mode & master_ff & (|any_ev);
    end
  end

  assign wake_req = wake_ff;

  // ********************************************************************
  // Assertions
  // ********************************************************************

  sequence s_req_wait;
    bus_req && avs_waitrequest;
  endsequence

  sequence s_clear_with_edge;
    wr_go && sel.valid && sel.field == pecint_pkg::FLD_FLAGS
      && (any_ev[sel.port] != 8'h00);
  endsequence

  a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_req_wait |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  a_irq_master_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_b) change_irq |-> master_ff && change_summary_flag)
    else $error("interrupt without master enable or flag");

  a_summary_or: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    change_summary_flag == ((port_ff[0].flags | port_ff[1].flags) != 8'h00))
    else $error("summary flag differs from OR of flags");

  a_rise_sets_flag: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    (rise_ev[0] != 8'h00) |=> ((port_ff[0].flags & $past(rise_ev[0]))
                               == $past(rise_ev[0])))
    else $error("rising edge did not set port A flag");

  a_fall_sets_flag: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    (fall_ev[1] != 8'h00) |=> ((port_ff[1].flags & $past(fall_ev[1]))
                               == $past(fall_ev[1])))
    else $error("falling edge did not set port B flag");

  a_flag_sticky: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !(avs_write && !avs_waitrequest) && port_ff[0].flags[3]
      |=> port_ff[0].flags[3])
    else $error("flag dropped without a clearing write");

  a_set_beats_clear: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    s_clear_with_edge |=> ((port_ff[$past(sel.port)].flags
                            & $past(any_ev[sel.port]))
                           == $past(any_ev[sel.port])))
    else $error("edge lost during flag clearing write");

  a_unimpl_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    ((port_ff[0] & ~{3{pecint_pkg::A_PIN_MASK}}) == '0)
      && ((port_ff[1] & ~{3{pecint_pkg::B_PIN_MASK}}) == '0))
    else $error("unimplemented register bit holds a one");

  a_buf_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !port_a_buf_en[0] |-> !rise_ev[0][0] && !fall_ev[0][0])
    else $error("edge seen on pin zero with buffer off");

  a_wake_flag: assert property (@(posedge sys_clk)
    disable iff (!rst_b) wake_req |-> change_summary_flag && master_ff)
    else $error("wake request before flag update");

  a_edge_single: assert property (@(posedge sys_clk)
    disable iff (!rst_b) (any_ev[0] != 8'h00) |=> (any_ev[0]
                                                   & $past(any_ev[0])) == 0)
    else $error("edge pulse longer than one cycle");

  a_wake_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    wake_req |-> $past(sleep_mode && master_ff && (any_ev != '0)))
    else $error("wake request without sleep, master enable or edge");

  a_flag_hw_set: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    (port_ff[0].flags & ~$past(port_ff[0].flags) & ~$past(any_ev[0]))
      == 8'h00)
    else $error("port A flag set without a detected edge");

  a_edge_is_change: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    (any_ev[0] & ~(pin_sync_ff[0] ^ $past(pin_sync_ff[0]))) == 8'h00)
    else $error("port A edge without a change of the pin sample");

  a_clear_drops: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    wr_go && sel.valid && sel.field == pecint_pkg::FLD_FLAGS && !sel.port
      && !avs_writedata[3] && !any_ev[0][3] |=> !port_ff[0].flags[3])
    else $error("flag not cleared by a written zero");

endmodule : pecint_top

// *** pecint_top_dummy_note_none.sv ***
// Holds no logic: the whole block sits in pecint_top.sv

// *** pecint_top_tb.sv ***
// Self-checking bench for the pin edge change block
`timescale 1ns/1ps

module pecint_top_tb;
  // Bus, pins and side-band signals
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [7:0] want_a, want_b, port_a_pins, port_b_pins;
  logic [1:0] port_a_buf_en;
  logic sleep_mode, change_irq, change_summary_flag, wake_req;
  int miscompares = 0;
  int samples_checked = 0;

  pecint_top u_pecint_top (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
    .port_a_buf_en(port_a_buf_en), .sleep_mode(sleep_mode),
    .change_irq(change_irq), .change_summary_flag(change_summary_flag),
    .wake_req(wake_req));

  pecint_pins u_pecint_pins (.sys_clk(sys_clk), .want_a(want_a),
    .want_b(want_b), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Request held until waitrequest is sampled low; one idle edge after it
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] v,
                        input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h000000, v};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, input logic [7:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    check("register read", {24'h000000, exp}, d);
    @(posedge sys_clk);
  endtask : bus_rd

  // Sync, edge and flag stages plus the model's own cycle fit in six
  task automatic set_pins(input logic [7:0] a, input logic [7:0] b);
    want_a <= a;
    want_b <= b;
    repeat (6) @(posedge sys_clk);
  endtask : set_pins

  // Counts wake cycles; the summary must already be up in each of them
  task automatic wake_watch(input logic [7:0] a, input int exp);
    int n;
    n = 0;
    want_a <= a;
    repeat (8) begin
      @(posedge sys_clk);
      if (wake_req === 1'b1) begin
        n++;
        check("wake summary", 32'h1, {31'h0, change_summary_flag});
      end
    end
    check("wake pulses", exp, n);
  endtask : wake_watch

  task automatic clr_flags();
    bus_wr(pecint_pkg::OFS_A_FLAGS, 8'h00, 4'h1);
    bus_wr(pecint_pkg::OFS_B_FLAGS, 8'h00, 4'h1);
  endtask : clr_flags

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_regs();
    logic [7:0] want;
    for (int i = 0; i < 8; i++) begin
      bus_rd(5'(i * 4), 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      bus_wr(5'(i * 4), 8'hFF, 4'h1);
      want = (i % 3 == 2) ? 8'h00 : pecint_pkg::PIN_MASK[i / 3];
      bus_rd(5'(i * 4), want);
    end
    bus_wr(pecint_pkg::OFS_A_RISE, 8'h00, 4'h0);
    bus_rd(pecint_pkg::OFS_A_RISE, 8'h3B);
    bus_wr(5'h1C, 8'hFF, 4'h1);
    bus_rd(5'h1C, 8'h00);
    bus_wr(pecint_pkg::OFS_CTRL, 8'hFF, 4'h1);
    bus_rd(pecint_pkg::OFS_CTRL, 8'h10);
  endtask : t_regs

  task automatic t_edges();
    bus_wr(pecint_pkg::OFS_A_RISE, 8'h28, 4'h1);
    bus_wr(pecint_pkg::OFS_A_FALL, 8'h30, 4'h1);
    bus_wr(pecint_pkg::OFS_B_RISE, 8'h80, 4'h1);
    bus_wr(pecint_pkg::OFS_B_FALL, 8'h40, 4'h1);
    set_pins(8'hFF, 8'hFF);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h28);
    bus_rd(pecint_pkg::OFS_B_FLAGS, 8'h80);
    check("irq", 32'h1, {31'h0, change_irq});
    clr_flags();
    set_pins(8'h00, 8'h00);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h30);
    bus_rd(pecint_pkg::OFS_B_FLAGS, 8'h40);
    clr_flags();
    check("summary", 32'h0, {31'h0, change_summary_flag});
  endtask : t_edges

  task automatic t_master();
    bus_wr(pecint_pkg::OFS_CTRL, 8'h00, 4'h1);
    set_pins(8'h08, 8'h00);
    check("summary", 32'h1, {31'h0, change_summary_flag});
    check("irq off", 32'h0, {31'h0, change_irq});
    bus_wr(pecint_pkg::OFS_CTRL, 8'h10, 4'h1);
    check("irq on", 32'h1, {31'h0, change_irq});
    bus_rd(pecint_pkg::OFS_CTRL, 8'h11);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h08);
  endtask : t_master

  task automatic t_clear();
    // Clear only what was seen, as software should
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h08);
    bus_wr(pecint_pkg::OFS_A_FLAGS, d[7:0] ^ 8'hFF, 4'h1);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h00);
    set_pins(8'h18, 8'h00);
    // Falling edge of pin four lands on the clearing write's store edge
    want_a <= 8'h08;
    repeat (2) @(posedge sys_clk);
    bus_wr(pecint_pkg::OFS_A_FLAGS, 8'h00, 4'h1);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h10);
  endtask : t_clear

  task automatic t_sleep();
    set_pins(8'h30, 8'h00);
    clr_flags();
    sleep_mode <= 1'b1;
    wake_watch(8'h00, 1);
    clr_flags();
    bus_wr(pecint_pkg::OFS_CTRL, 8'h00, 4'h1);
    wake_watch(8'h08, 0);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h08);
    sleep_mode <= 1'b0;
    bus_wr(pecint_pkg::OFS_CTRL, 8'h10, 4'h1);
  endtask : t_sleep

  task automatic t_buf();
    clr_flags();
    bus_wr(pecint_pkg::OFS_A_RISE, 8'h03, 4'h1);
    bus_wr(pecint_pkg::OFS_A_FALL, 8'h00, 4'h1);
    port_a_buf_en <= 2'b00;
    set_pins(8'h0B, 8'h00);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h00);
    port_a_buf_en <= 2'b01;
    set_pins(8'h08, 8'h00);
    set_pins(8'h0B, 8'h00);
    bus_rd(pecint_pkg::OFS_A_FLAGS, 8'h01);
  endtask : t_buf

  // ******************************************************************
  // Run
  // ******************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole run is a few hundred cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  // Reset, priming wait, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h00000000;
    want_a = 8'h00;
    want_b = 8'h00;
    port_a_buf_en = 2'b11;
    sleep_mode = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_edges();
    t_master();
    t_clear();
    t_sleep();
    t_buf();
    end_of_test();
  end
endmodule : pecint_top_tb
